// ==== roc_coil_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module roc_coil_model (
   input  wire logic [9:0] coil_drive_in,
   output logic      [9:0] contact_closed_out
);
   // Make contacts: open while the coil rests
   assign contact_closed_out = coil_drive_in;
endmodule
`default_nettype wire

// ==== roc_pkg.sv ====
package roc_pkg;
   // -----------------------------------------------------------------
   // Output set and signal counts
   // -----------------------------------------------------------------
   localparam int NUM_TRIP   = 8;
   localparam int NUM_OUT    = NUM_TRIP + 2;
   localparam int NUM_SRC    = 16;
   localparam int NUM_LOGIC  = 4;
   localparam int NUM_ROUTED = NUM_SRC + NUM_LOGIC;
   localparam int ALARM_IDX  = NUM_TRIP;
   localparam int SVC_IDX    = NUM_TRIP + 1;

   // -----------------------------------------------------------------
   // Crosspoint codes
   // -----------------------------------------------------------------
   localparam logic [1:0] XP_NONE    = 2'h0;
   localparam logic [1:0] XP_ROUTED  = 2'h1;
   localparam logic [1:0] XP_LATCHED = 2'h2;

   // -----------------------------------------------------------------
   // Register offsets (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS   = 8'h00;
   localparam logic [7:0] ADDR_FORCE_EN = 8'h04;
   localparam logic [7:0] ADDR_POLARITY = 8'h08;
   localparam logic [7:0] ADDR_RELEASE  = 8'h0C;
   localparam logic [7:0] ADDR_LATCHED  = 8'h10;
   localparam logic [7:0] ADDR_LOGIC_EN = 8'h14;
   localparam logic [7:0] ADDR_MATRIX   = 8'h40;
   localparam logic [7:0] ADDR_MAT_END  = ADDR_MATRIX + 8'(4 * NUM_ROUTED);

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int         FORCE_FLAG_BIT = 0;
   localparam logic [9:0] POLARITY_RST   = 10'h000;
   localparam logic [9:0] LOGIC_EN_RST   = 10'h000;
endpackage

// ==== roc_relay_output_control.sv ====
// Functional notes
// RULE1: every crosspoint is routed, routed-with-latch, or not routed
// RULE2: any internal signal may be routed to any output
// RULE3: trip outputs driven by matrix, logic function outputs, or forcing
// RULE4: built logic function output gets its matrix assignment automatically
// RULE5: per-output latching; latched output cleared only by latch release
// RULE6: break-contact polarity inverts the driven output position
// RULE7: status reads 1 when coil energised, 0 otherwise
// RULE8: status reports coil energisation alike for make and break contacts
// RULE9: de-energised coil is the resting contact state
// RULE10: operator sets force flag before forcing; otherwise forcing ignored
// RULE11: output status writable only while force flag is on
// RULE12: outputs are trip outputs, one alarm output, one service output
// RULE13: latched output holds after source drops until released
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module roc_relay_output_control (
   input  wire logic                          clk_in,
   input  wire logic                          rst_b_in,
   input  wire logic                          clk_en_in,
   input  wire logic [roc_pkg::NUM_SRC-1:0]   int_sig_in,
   input  wire logic [roc_pkg::NUM_LOGIC-1:0] logic_fn_in,
   input  wire logic [roc_pkg::NUM_LOGIC-1:0] logic_built_in,
   input  wire logic                          wb_cyc_in,
   input  wire logic                          wb_stb_in,
   input  wire logic                          wb_we_in,
   input  wire logic [7:0]                    wb_adr_in,
   input  wire logic [3:0]                    wb_sel_in,
   input  wire logic [31:0]                   wb_dat_in,
   output logic [31:0]                        wb_dat_out,
   output logic                               wb_ack_out,
   output logic [roc_pkg::NUM_TRIP-1:0]       trip_output_out,
   output logic                               alarm_signal_output_out,
   output logic                               service_status_output_out
);
   localparam int NO = roc_pkg::NUM_OUT;
   localparam int NR = roc_pkg::NUM_ROUTED;

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   logic [NR-1:0] src_s1_q;
   logic [NR-1:0] src_s2_q;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         src_s1_q <= '0;
         src_s2_q <= '0;
      end else if (clk_en_in) begin
         src_s1_q <= {logic_fn_in, int_sig_in};
         src_s2_q <= src_s1_q;
      end
   end

   logic [roc_pkg::NUM_LOGIC-1:0] built_s1_q;
   logic [roc_pkg::NUM_LOGIC-1:0] built_s2_q;
   logic [roc_pkg::NUM_LOGIC-1:0] built_s3_q;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         built_s1_q <= '0;
         built_s2_q <= '0;
         built_s3_q <= '0;
      end else if (clk_en_in) begin
         built_s1_q <= logic_built_in;
         built_s2_q <= built_s1_q;
         built_s3_q <= built_s2_q;
      end
   end

   wire [roc_pkg::NUM_LOGIC-1:0] built_rise = built_s2_q & ~built_s3_q;

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   wire       bus_req   = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   wire       wr_req    = bus_req & wb_we_in & wb_sel_in[0];
   wire       wr_req_hi = bus_req & wb_we_in & wb_sel_in[1];
   wire       sel_stat  = (wb_adr_in == roc_pkg::ADDR_STATUS);
   wire       sel_force = (wb_adr_in == roc_pkg::ADDR_FORCE_EN);
   wire       sel_pol   = (wb_adr_in == roc_pkg::ADDR_POLARITY);
   wire       sel_rel   = (wb_adr_in == roc_pkg::ADDR_RELEASE);
   wire       sel_lat   = (wb_adr_in == roc_pkg::ADDR_LATCHED);
   wire       sel_len   = (wb_adr_in == roc_pkg::ADDR_LOGIC_EN);
   wire       sel_mat   = (wb_adr_in >= roc_pkg::ADDR_MATRIX) && (wb_adr_in < roc_pkg::ADDR_MAT_END)
                          && (wb_adr_in[1:0] == 2'h0);
   wire [7:0] mat_off   = wb_adr_in - roc_pkg::ADDR_MATRIX;
   wire [5:0] mat_row   = mat_off[7:2];
   wire       wr_word   = wr_req & wr_req_hi;
   wire       wr_force  = wr_req & sel_force;
   wire       wr_pol    = wr_word & sel_pol;
   wire       wr_len    = wr_word & sel_len;
   wire       wr_stat   = wr_word & sel_stat;
   wire       wr_rel    = wr_word & sel_rel;
   wire       wr_mat    = wr_req & sel_mat;
   wire       rd_req    = bus_req & ~wb_we_in;

   // -----------------------------------------------------------------
   // Configuration registers
   // -----------------------------------------------------------------
   logic           force_q;
   logic [NO-1:0]  polarity_q;
   logic [NO-1:0]  forced_val_q;
   logic [NO-1:0]  latched_q;
   logic [NO-1:0]  coil_q;
   logic [NO-1:0]  logic_en_q;
   logic [1:0]     xp_q [NR][NO];

   wire  [NO-1:0]  wr_data10 = {wb_dat_in[9:8], wb_dat_in[7:0]};
   wire  [NO-1:0]  rel_mask  = wr_rel ? wr_data10 : '0;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         force_q <= 1'b0;
      end else if (clk_en_in && wr_force) begin
         force_q <= wb_dat_in[roc_pkg::FORCE_FLAG_BIT];
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         polarity_q <= roc_pkg::POLARITY_RST;
      end else if (clk_en_in && wr_pol) begin
         polarity_q <= wr_data10;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         logic_en_q <= roc_pkg::LOGIC_EN_RST;
      end else if (clk_en_in && wr_len) begin
         logic_en_q <= wr_data10;
      end
   end

   // -----------------------------------------------------------------
   // Forced status
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         forced_val_q <= '0;
      end else if (clk_en_in) begin
         if (!force_q) begin
            forced_val_q <= coil_q;
         end else if (wr_stat) begin
            forced_val_q <= wr_data10; // RULE11
         end
      end
   end

   // -----------------------------------------------------------------
   // Output routing matrix
   // -----------------------------------------------------------------
   genvar r;
   genvar o;
   generate
      for (r = 0; r < NR; r++) begin : g_row
         for (o = 0; o < NO; o++) begin : g_col
            wire auto_set;

            if (r >= roc_pkg::NUM_SRC && o < roc_pkg::NUM_TRIP
                && (r - roc_pkg::NUM_SRC) == o % roc_pkg::NUM_LOGIC) begin : g_auto
               assign auto_set = built_rise[r-roc_pkg::NUM_SRC] && (xp_q[r][o] == roc_pkg::XP_NONE);
            end else begin : g_fixed
               assign auto_set = 1'b0;
            end

            always_ff @(posedge clk_in or negedge rst_b_in) begin
               if (!rst_b_in) begin
                  xp_q[r][o] <= roc_pkg::XP_NONE;
               end else if (clk_en_in) begin
                  if (auto_set) begin
                     xp_q[r][o] <= roc_pkg::XP_ROUTED; // RULE4
                  end else if (wr_mat && mat_row == 6'(r)) begin
                     xp_q[r][o] <= wb_dat_in[2*o +: 2]; // RULE1 RULE2
                  end
               end
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------------
   // Per-output drive and latch
   // -----------------------------------------------------------------
   logic [NO-1:0] hit_plain;
   logic [NO-1:0] hit_latch;
   logic [NO-1:0] latch_d;

   always_comb begin
      hit_plain = '0;
      hit_latch = '0;
      for (int oo = 0; oo < NO; oo++) begin
         for (int rr = 0; rr < NR; rr++) begin
            if (src_s2_q[rr] && xp_is_plain(xp_q[rr][oo])) begin
               hit_plain[oo] = 1'b1;
            end
            if (src_s2_q[rr] && xp_is_latch(xp_q[rr][oo])) begin
               hit_latch[oo] = 1'b1;
            end
         end
      end
   end

   // Direct logic function drive of trip outputs
   logic [NO-1:0] logic_drive;

   always_comb begin
      logic_drive = '0;
      for (int oo = 0; oo < roc_pkg::NUM_TRIP; oo++) begin
         logic_drive[oo] = logic_en_q[oo] & logic_fn_in_s(oo); // RULE3
      end
   end

   function automatic logic logic_fn_in_s(input int idx);
      logic_fn_in_s = src_s2_q[roc_pkg::NUM_SRC + (idx % roc_pkg::NUM_LOGIC)];
   endfunction

   function automatic logic xp_is_plain(input logic [1:0] code);
      xp_is_plain = (code == roc_pkg::XP_ROUTED);
   endfunction

   function automatic logic xp_is_latch(input logic [1:0] code);
      xp_is_latch = (code == roc_pkg::XP_LATCHED);
   endfunction

   assign latch_d = hit_latch | (latched_q & ~rel_mask); // RULE5 RULE13

   wire [NO-1:0] normal_coil = hit_plain | latched_q | logic_drive;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         latched_q <= '0;
      end else if (clk_en_in) begin
         latched_q <= latch_d;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         coil_q <= '0;
      end else if (clk_en_in) begin
         coil_q <= force_q ? forced_val_q : normal_coil; // RULE3 RULE10
      end
   end

   // -----------------------------------------------------------------
   // Pin drive with polarity
   // -----------------------------------------------------------------
   logic [NO-1:0] pin_q;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pin_q <= '0; // RULE9
      end else if (clk_en_in) begin
         pin_q <= coil_q ^ polarity_q; // RULE6
      end
   end

   assign trip_output_out           = pin_q[roc_pkg::NUM_TRIP-1:0]; // RULE12
   assign alarm_signal_output_out   = pin_q[roc_pkg::ALARM_IDX];
   assign service_status_output_out = pin_q[roc_pkg::SVC_IDX];

   // -----------------------------------------------------------------
   // Read back
   // -----------------------------------------------------------------
   logic [31:0] rd_mat;

   always_comb begin
      rd_mat = '0;
      for (int rr = 0; rr < NR; rr++) begin
         if (mat_row == 6'(rr)) begin
            for (int oo = 0; oo < NO; oo++) begin
               rd_mat[2*oo +: 2] = xp_q[rr][oo];
            end
         end
      end
   end

   wire [31:0] rd_val = sel_stat  ? {22'h000000, coil_q} : // RULE7 RULE8
                        sel_force ? {31'h00000000, force_q} :
                        sel_pol   ? {22'h000000, polarity_q} :
                        sel_lat   ? {22'h000000, latched_q} :
                        sel_len   ? {22'h000000, logic_en_q} :
                        sel_mat   ? rd_mat : 32'h00000000;

   // -----------------------------------------------------------------
   // Bus answer
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wb_ack_out <= 1'b0;
      end else if (clk_en_in) begin
         wb_ack_out <= bus_req;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wb_dat_out <= 32'h00000000;
      end else if (clk_en_in && rd_req) begin
         wb_dat_out <= rd_val;
      end
   end
endmodule
`default_nettype wire

// ==== roc_relay_output_control_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module roc_relay_output_control_asserts (
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   input wire logic        clk_en_in,
   input wire logic [15:0] int_sig_in,
   input wire logic [3:0]  logic_fn_in,
   input wire logic [3:0]  logic_built_in,
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_we_in,
   input wire logic [7:0]  wb_adr_in,
   input wire logic [3:0]  wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic        wb_ack_out,
   input wire logic [7:0]  trip_output_out,
   input wire logic        alarm_signal_output_out,
   input wire logic        service_status_output_out
);
   // ----
   // Bus and pin checks
   // ----
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   wire logic       req  = wb_cyc_in & wb_stb_in & !wb_ack_out & clk_en_in;
   wire logic       hole = (wb_adr_in >= 8'h18 && wb_adr_in < 8'h40) || wb_adr_in >= roc_pkg::ADDR_MAT_END;
   wire logic [9:0] pins = {service_status_output_out, alarm_signal_output_out, trip_output_out};
   wire logic       rd_req  = req & !wb_we_in;
   wire logic       rd_hole = rd_req & hole;
   wire logic       rd_rel  = rd_req & (wb_adr_in == roc_pkg::ADDR_RELEASE);
   wire logic       rd_stat = rd_req & (wb_adr_in == roc_pkg::ADDR_STATUS);
   a_ack_follows_req: assert property (req |=> wb_ack_out) else $error("ack missing");
   a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
   a_ack_has_cause: assert property (wb_ack_out |-> $past(req)) else $error("ack without request");
   a_hole_reads_zero: assert property (wb_ack_out && $past(rd_hole) |-> wb_dat_out == 32'h0)
      else $error("unmapped read not zero");
   a_release_reads_zero: assert property (wb_ack_out && $past(rd_rel) |-> wb_dat_out == 32'h0)
      else $error("release read not zero");
   a_status_ten_bits: assert property (wb_ack_out && $past(rd_stat) |-> wb_dat_out[31:10] == 22'h0)
      else $error("status upper bits set");
   a_pins_rest_reset: assert property ($rose(rst_b_in) |-> pins == 10'h0) else $error("pins not at rest");
   a_pins_frozen: assert property (!clk_en_in |=> $stable(pins)) else $error("pins moved while frozen");
endmodule
bind roc_relay_output_control roc_relay_output_control_asserts u_chk (
   .clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in), .int_sig_in(int_sig_in),
   .logic_fn_in(logic_fn_in), .logic_built_in(logic_built_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
   .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
   .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .trip_output_out(trip_output_out),
   .alarm_signal_output_out(alarm_signal_output_out), .service_status_output_out(service_status_output_out));
`default_nettype wire

// ==== roc_relay_output_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module roc_relay_output_control_tb;
   logic        clk_in = 0, rst_b_in = 0, clk_en_in = 1, req = 0, we = 0, alarm, svc, ack;
   logic [15:0] int_sig = 16'h0;
   logic [3:0]  fn = 4'h0, built = 4'h0;
   logic [7:0]  adr = 8'h0, trip;
   logic [31:0] dat = 32'h0, rdat, rd;
   logic [9:0]  contact;
   int          n_errors = 0, samples_checked = 0;
   roc_relay_output_control dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in), .int_sig_in(int_sig),
      .logic_fn_in(fn), .logic_built_in(built), .wb_cyc_in(req), .wb_stb_in(req), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(4'hF), .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack), .trip_output_out(trip),
      .alarm_signal_output_out(alarm), .service_status_output_out(svc));
   roc_coil_model u_coil (.coil_drive_in({svc, alarm, trip}), .contact_closed_out(contact));
   initial forever #2.5 clk_in = ~clk_in;
   task automatic close_out;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_in);
      req <= 1; we <= w; adr <= a; dat <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_in);
         if (ack === 1'b1) break;
      end
      rd = rdat;
      req <= 0;
      if (i == 20) begin `CHK("ack", 1'b1, 1'b0) close_out(); end
   endtask
   task automatic t_reset;
      wb(0, roc_pkg::ADDR_POLARITY, 32'h0);
      `CHK("polarity", 32'h0, rd)
      `CHK("contacts", 10'h0, contact)
      clk_en_in <= 0;
      repeat (4) @(posedge clk_in);
      clk_en_in <= 1;
      wb(0, 8'h20, 32'h0);
      `CHK("hole", 32'h0, rd)
      $display("reset test done");
   endtask
   task automatic t_route;
      wb(1, roc_pkg::ADDR_MATRIX + 8'h0C, 32'h0002_0001);
      wb(1, roc_pkg::ADDR_MATRIX + 8'h3C, 32'h0004_0000);
      clk_en_in <= 0;
      int_sig <= 16'h8008;
      repeat (8) @(posedge clk_in);
      `CHK("frozen", 10'h0, {svc, alarm, trip})
      clk_en_in <= 1;
      repeat (8) @(posedge clk_in);
      wb(0, roc_pkg::ADDR_STATUS, 32'h0);
      `CHK("status", 32'h301, rd)
      `CHK("contacts", 10'h301, contact)
      int_sig <= 16'h0;
      repeat (8) @(posedge clk_in);
      `CHK("held", 10'h100, {svc, alarm, trip})
      wb(0, roc_pkg::ADDR_LATCHED, 32'h0);
      `CHK("latched", 32'h100, rd)
      wb(1, roc_pkg::ADDR_RELEASE, 32'h3FF);
      repeat (8) @(posedge clk_in);
      `CHK("released", 10'h0, {svc, alarm, trip})
      $display("route test done");
   endtask
   task automatic t_polarity;
      wb(1, roc_pkg::ADDR_POLARITY, 32'h200);
      repeat (8) @(posedge clk_in);
      `CHK("svc_pin", 1'b1, svc)
      wb(0, roc_pkg::ADDR_STATUS, 32'h0);
      `CHK("status", 32'h0, rd)
      wb(1, roc_pkg::ADDR_POLARITY, 32'h0);
      $display("polarity test done");
   endtask
   task automatic t_force;
      wb(1, roc_pkg::ADDR_STATUS, 32'h1);
      repeat (8) @(posedge clk_in);
      `CHK("ignored", 8'h0, trip)
      wb(1, roc_pkg::ADDR_FORCE_EN, 32'h1);
      wb(1, roc_pkg::ADDR_STATUS, 32'h81);
      repeat (8) @(posedge clk_in);
      wb(0, roc_pkg::ADDR_STATUS, 32'h0);
      `CHK("forced", 32'h81, rd)
      `CHK("forced_pin", 8'h81, trip)
      wb(1, roc_pkg::ADDR_FORCE_EN, 32'h0);
      $display("force test done");
   endtask
   task automatic t_logic;
      built <= 4'h2;
      repeat (8) @(posedge clk_in);
      wb(0, roc_pkg::ADDR_MATRIX + 8'h44, 32'h0);
      `CHK("auto_route", 32'h404, rd)
      fn <= 4'h2;
      repeat (8) @(posedge clk_in);
      `CHK("logic_pins", 8'h22, trip)
      wb(1, roc_pkg::ADDR_LOGIC_EN, 32'h004);
      wb(0, roc_pkg::ADDR_LOGIC_EN, 32'h0);
      `CHK("logic_en", 32'h4, rd)
      fn <= 4'h4;
      repeat (8) @(posedge clk_in);
      `CHK("direct_pin", 8'h04, trip)
      $display("logic test done");
   endtask
   initial begin
      repeat (16) @(posedge clk_in);
      rst_b_in <= 1;
      t_reset();
      t_route();
      t_polarity();
      t_force();
      t_logic();
      close_out();
   end
endmodule
`default_nettype wire
